// file: rtl/gpc_cfg.svh
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
`define GPC_ADDR_PAGE 8'ha0
`define GPC_ADDR_PADCTL 8'hb5
`define GPC_PAGE_RST 8'h00
`define GPC_BIT_STROBE 7
`define GPC_BIT_PULLOFF 6
`define GPC_BIT_KEYSCAN 5
`define GPC_BIT_DRV2X 4
`define GPC_BIT_LEDMID 3
`define GPC_BIT_PINMID 2
`define GPC_LED_HI 1
`define GPC_LED_LO 0
`define GPC_SETTLE_CYC 2'd2
`define GPC_PADCTL_RST 8'h0c
`define GPC_LED_PIN 5
`define GPC_MODE_PIN_LO 1
`define GPC_ROFF_PIN_HI 2
`define GPC_SCAN_PIN_HI 3
`endif

// file: rtl/gpc_pad_control_regs.sv
`include "gpc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module gpc_pad_control_regs
    import gpc_pkg::*;
#(
    parameter int GPIO_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWr,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrBitWr,
    input wire logic [2:0] sfrBitSel,
    input wire logic sfrBitVal,
    output logic [7:0] sfrRdata,
    input wire logic [7:0] pagedLowAddr,
    output logic [15:0] pagedAddr,
    input wire logic [GPIO_W-1:0] portZeroData,
    input wire logic [GPIO_W-1:0] pushPull,
    output logic [GPIO_W-1:0] pullUpEn,
    output logic [GPIO_W-1:0] forceLow,
    output logic doubleDrive,
    output logic ledPinMidThreshold,
    output logic pinMidThreshold,
    output logic [1:0] ledCurrentLevel,
    output logic ledCurrentOn,
    output logic padUpdateBusy
);
    initial begin
        if (GPIO_W < 6) $error("gpio width must reach line 5");
    end
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] page_r;
    logic [7:0] pad_r;
    logic pullOffLat_r;
    logic keyScanLat_r;
    logic [1:0] settle_r;
    gpc_latch_t state_r;
    logic [7:0] wrPage;
    logic [7:0] wrPad;
    logic hitPage;
    logic hitPad;

    function automatic logic [7:0] applyWrite(input logic [7:0] cur);
        logic [7:0] v;
        v = cur;
        if (sfrWr) begin
            v = sfrWdata;
        end else if (sfrBitWr) begin
            v[sfrBitSel] = sfrBitVal;
        end
        return v;
    endfunction : applyWrite

    assign hitPage = (sfrWr || sfrBitWr) && (sfrAddr == `GPC_ADDR_PAGE);
    assign hitPad = (sfrWr || sfrBitWr) && (sfrAddr == `GPC_ADDR_PADCTL);
    assign wrPage = applyWrite(page_r);
    assign wrPad = applyWrite(pad_r);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            page_r <= `GPC_PAGE_RST;
        end else if (hitPage) begin
            page_r <= wrPage;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pad_r <= `GPC_PADCTL_RST;
        end else if (hitPad) begin
            pad_r <= wrPad;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // the pad latches hold through cpu reset on silicon; here they clear for a known start
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= GPC_IDLE;
            pullOffLat_r <= 1'b0;
            keyScanLat_r <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            case (state_r)
                GPC_IDLE: begin
                    if (pad_r[`GPC_BIT_STROBE]) begin
                        state_r <= GPC_OPEN;
                    end
                end
                GPC_OPEN: begin
                    pullOffLat_r <= pad_r[`GPC_BIT_PULLOFF];
                    keyScanLat_r <= pad_r[`GPC_BIT_KEYSCAN];
                    if (!pad_r[`GPC_BIT_STROBE]) begin
                        state_r <= GPC_SETTLE;
                        settle_r <= `GPC_SETTLE_CYC - 2'd1;
                    end
                end
                GPC_SETTLE: begin
                    // capture already ended in GPC_OPEN; this two-clock window only counts down to idle
                    if (settle_r == 2'h0) begin
                        state_r <= GPC_IDLE;
                    end else begin
                        settle_r <= settle_r - 2'd1;
                    end
                end
                default: state_r <= GPC_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfrRdata <= 8'h00;
        end else if (sfrAddr == `GPC_ADDR_PAGE) begin
            sfrRdata <= page_r;
        end else if (sfrAddr == `GPC_ADDR_PADCTL) begin
            sfrRdata <= {pad_r[`GPC_BIT_STROBE], pullOffLat_r, keyScanLat_r,
                         pad_r[`GPC_BIT_DRV2X:0]};
        end else begin
            sfrRdata <= 8'h00;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pagedAddr <= 16'h0000;
        end else begin
            pagedAddr <= {page_r, pagedLowAddr};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pullUpEn <= '0;
            forceLow <= '0;
        end else begin
            for (int i = 0; i < GPIO_W; i++) begin
                pullUpEn[i] <= !pushPull[i];
                forceLow[i] <= 1'b0;
                if (i >= `GPC_MODE_PIN_LO && i <= `GPC_ROFF_PIN_HI && pullOffLat_r) begin
                    pullUpEn[i] <= 1'b0;
                end
                if (i >= `GPC_MODE_PIN_LO && i <= `GPC_SCAN_PIN_HI && keyScanLat_r) begin
                    pullUpEn[i] <= 1'b0;
                    forceLow[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            doubleDrive <= 1'b0;
            ledPinMidThreshold <= 1'b1;
            pinMidThreshold <= 1'b1;
            ledCurrentLevel <= GPC_LED_OFF;
            ledCurrentOn <= 1'b0;
            padUpdateBusy <= 1'b0;
        end else begin
            doubleDrive <= pad_r[`GPC_BIT_DRV2X];
            ledPinMidThreshold <= pad_r[`GPC_BIT_LEDMID];
            pinMidThreshold <= pad_r[`GPC_BIT_PINMID];
            ledCurrentLevel <= pad_r[`GPC_LED_HI:`GPC_LED_LO];
            // level alone never lights the led; gpio 5 data gates it
            ledCurrentOn <= portZeroData[`GPC_LED_PIN] &&
                            (pad_r[`GPC_LED_HI:`GPC_LED_LO] != GPC_LED_OFF);
            padUpdateBusy <= (state_r != GPC_IDLE);
        end
    end
endmodule : gpc_pad_control_regs
`default_nettype wire

// file: rtl/gpc_pkg.sv
package gpc_pkg;
    typedef enum logic [2:0] {
        GPC_IDLE = 3'b001,
        GPC_OPEN = 3'b010,
        GPC_SETTLE = 3'b100
    } gpc_latch_t;
    typedef enum logic [1:0] {
        GPC_LED_OFF = 2'h0,
        GPC_LED_LOW = 2'h1,
        GPC_LED_NOM = 2'h2,
        GPC_LED_HIGH = 2'h3
    } gpc_led_t;
endpackage : gpc_pkg

// file: testbench/gpc_pad_control_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module gpc_pad_control_regs_properties
    import gpc_pkg::*;
#(parameter int GPIO_W = 8) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWr,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic [7:0] pagedLowAddr,
    input wire logic [15:0] pagedAddr,
    input wire logic [GPIO_W-1:0] portZeroData,
    input wire logic [GPIO_W-1:0] pushPull,
    input wire logic [GPIO_W-1:0] pullUpEn,
    input wire logic [GPIO_W-1:0] forceLow,
    input wire logic doubleDrive,
    input wire logic [1:0] ledCurrentLevel,
    input wire logic ledCurrentOn,
    input wire logic padUpdateBusy
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
////////////////////
a_page_store: assert property (sfrWr && sfrAddr == 8'ha0
    |-> ##2 pagedAddr[15:8] == $past(sfrWdata, 2)) else $error("page byte");
a_paged_low: assert property (1 |-> ##1 pagedAddr[7:0] == $past(pagedLowAddr))
    else $error("low byte");
a_led_zero: assert property (ledCurrentLevel == 2'h0 [*2] |-> !ledCurrentOn)
    else $error("led level");
a_led_switch: assert property (!portZeroData[5] [*2] |-> !ledCurrentOn)
    else $error("led switch");
a_scan_lines: assert property (forceLow[1] |-> forceLow[3:1] == 3'h7
    && pullUpEn[3:1] == 3'h0) else $error("scan lines");
a_pull_pp: assert property (1 |-> ##1 pullUpEn[4] == !$past(pushPull[4]))
    else $error("pull mode");
a_roff_pins: assert property ($past(sfrAddr) == 8'hb5 && sfrRdata[6]
    |-> pullUpEn[2:1] == 2'h0) else $error("roff pins");
a_busy_end: assert property (sfrWr && sfrAddr == 8'hb5 && !sfrWdata[7]
    |-> ##[1:5] !padUpdateBusy) else $error("busy");
// no writes after so that either output lag is covered
a_drive_led: assert property ((sfrWr && sfrAddr == 8'hb5) ##1 !sfrWr [*2]
    |-> {doubleDrive, ledCurrentLevel} == $past({sfrWdata[4], sfrWdata[1:0]}, 2))
    else $error("drive led");
c_busy: cover property (padUpdateBusy);
c_scan: cover property (forceLow[1]);
c_led: cover property (ledCurrentOn);
endmodule : gpc_pad_control_regs_properties
bind gpc_pad_control_regs gpc_pad_control_regs_properties #(.GPIO_W(GPIO_W)) chk_i (.*);
`default_nettype wire

// file: testbench/gpc_pad_control_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module gpc_pad_control_regs_tb_top
    import gpc_pkg::*;
;
logic clk = 1'b0, sys_rst = 1'b1, sfrWr = 1'b0, sfrBitWr = 1'b0, sfrBitVal = 1'b0;
logic [2:0] sfrBitSel = 3'h0;
logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, pagedLowAddr = 8'h00, sfrRdata;
logic [7:0] portZeroData = 8'h00, pushPull = 8'hf0, pullUpEn, forceLow;
logic [15:0] pagedAddr;
logic doubleDrive, ledPinMidThreshold, pinMidThreshold, ledCurrentOn, padUpdateBusy;
logic [1:0] ledCurrentLevel;
int errCount = 0, samplesChecked = 0;
always #10 clk = ~clk;
gpc_pad_control_regs gpc_pad_control_regs_i (.*);
////////////////////
task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask : cyc
task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
        errCount++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : cmp
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWr <= 1'b1;
    @(posedge clk);
    sfrWr <= 1'b0;
endtask : wr
task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfrAddr <= a;
    cyc(2);
    cmp({8'h00, sfrRdata}, {8'h00, e});
endtask : rd
task automatic endSim;
    if (errCount == 0 && samplesChecked > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask : endSim
////////////////////
initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'ha0, 8'h00);
    rd(8'hb5, 8'h0c);
    cmp({ledPinMidThreshold, pinMidThreshold, doubleDrive, ledCurrentLevel}, 16'h18);
    cmp({8'h00, pullUpEn}, 16'h000f);
    wr(8'ha0, 8'ha5);
    @(posedge clk) {sfrBitWr, sfrBitSel, pagedLowAddr} <= {1'b1, 3'h0, 8'h3c};
    @(posedge clk) sfrBitWr <= 1'b0;
    wr(8'h77, 8'hff);
    rd(8'h77, 8'h00);
    rd(8'ha0, 8'ha4);
    cmp(pagedAddr, 16'ha43c);
    wr(8'hb5, 8'h13);
    rd(8'hb5, 8'h13);
    cmp({ledPinMidThreshold, pinMidThreshold, doubleDrive, ledCurrentLevel}, 16'h07);
    @(posedge clk) portZeroData <= 8'h20;
    for (int i = 0; i < 4; i++) begin
        wr(8'hb5, 8'(i));
        cyc(3);
        cmp({15'h0, ledCurrentOn}, {15'h0, i != 0});
    end
    @(posedge clk) portZeroData <= 8'h00;
    cyc(3);
    cmp({15'h0, ledCurrentOn}, 16'h0);
    // strobe open: pull-off reaches the pads only after the open state captures it
    wr(8'hb5, 8'hc0);
    cyc(3);
    cmp({8'h00, pullUpEn}, 16'h0009);
    wr(8'hb5, 8'h40);
    cyc(5);
    cmp({15'h0, padUpdateBusy}, 16'h0);
    wr(8'hb5, 8'h00);
    rd(8'hb5, 8'h40);
    cmp({8'h00, pullUpEn}, 16'h0009);
    wr(8'hb5, 8'ha0);
    cyc(3);
    cmp({15'h0, padUpdateBusy}, 16'h1);
    wr(8'hb5, 8'h20);
    cyc(5);
    rd(8'hb5, 8'h20);
    cmp({pullUpEn, forceLow}, 16'h010e);
    endSim;
end
initial begin
    repeat (3000) @(posedge clk);
    errCount++;
    endSim;
end
endmodule : gpc_pad_control_regs_tb_top
`default_nettype wire
